// >>> verilog/cpg_defines.vh
`ifndef CPG_DEFINES_VH
`define CPG_DEFINES_VH

// register offsets on the control port
`define CPG_OFF_RX_GAIN      8'h14
`define CPG_OFF_TX_GAIN      8'h15
`define CPG_OFF_RING_CTRL1   8'h16

// reset values
`define CPG_RST_RX_GAIN      8'h00
`define CPG_RST_TX_GAIN      8'h00
`define CPG_RST_RING_CTRL1   8'h96

// ring_validation_control_one fields
`define CPG_DELAY_LO_MSB     7
`define CPG_DELAY_LO_LSB     6
`define CPG_LIMIT_MSB        5
`define CPG_LIMIT_LSB        0

// gain field: value 64 is unity, result is shifted down by 6
`define CPG_GAIN_UNITY       8'h40
`define CPG_GAIN_SHIFT       6

// timing
`define CPG_CLK_HZ           50000000
`define CPG_TICK_MS          1
`define CPG_CYCLES_PER_MS    ((`CPG_CLK_HZ / 1000) * `CPG_TICK_MS)
`define CPG_DELAY_STEP_MS    256
`define CPG_DELAY_WIDTH      11

`endif

// >>> verilog/cpg_ring_delay.v
`include "cpg_defines.vh"

module cpg_ring_delay #(
  parameter CNT_W = `CPG_DELAY_WIDTH
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // timing and control
  input  wire             ms_tick,
  input  wire [2:0]       delay_code,
  input  wire             ring_validated,
  // indication
  output reg              ring_indicate
);

  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [1:0]       state_reg;
  reg [1:0]       state_next;
  reg [CNT_W-1:0] ms_cnt_reg;
  reg [CNT_W-1:0] ms_cnt_next;
  reg [CNT_W-1:0] target_reg;
  reg [CNT_W-1:0] target_next;
  reg             ind_next;

  // code n waits n steps of 256 ms; codes between 010 and 111 follow the same line
  function [CNT_W-1:0] cpg_delay_ms;
    input [2:0]  code;
    reg   [31:0] full;
    begin
      full         = code * `CPG_DELAY_STEP_MS;
      cpg_delay_ms = full[CNT_W-1:0];
    end
  endfunction

  always @*
  begin
    state_next  = state_reg;
    ms_cnt_next = ms_cnt_reg;
    target_next = target_reg;
    ind_next    = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (ring_validated)
        begin
          if (delay_code == 3'h0)
            ind_next = 1'b1;
          else
          begin
            ms_cnt_next = {CNT_W{1'b0}};
            target_next = cpg_delay_ms(delay_code);
            state_next  = ST_WAIT;
          end
        end
      end
      ST_WAIT:
      begin
        if (ring_validated)
        begin
          // a fresh validation restarts the wait with the current code
          ms_cnt_next = {CNT_W{1'b0}};
          target_next = cpg_delay_ms(delay_code);
          if (delay_code == 3'h0)
          begin
            ind_next   = 1'b1;
            state_next = ST_IDLE;
          end
        end
        else if (ms_tick)
        begin
          ms_cnt_next = ms_cnt_reg + 1'b1;
          if (ms_cnt_reg + 1'b1 == target_reg)
          begin
            ind_next   = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_reg     <= ST_IDLE;
      ms_cnt_reg    <= {CNT_W{1'b0}};
      target_reg    <= {CNT_W{1'b0}};
      ring_indicate <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      ms_cnt_reg    <= ms_cnt_next;
      target_reg    <= target_next;
      ring_indicate <= ind_next;
    end
  end

endmodule // cpg_ring_delay

// >>> verilog/cpg_regs.v
`include "cpg_defines.vh"

module cpg_regs #(
  parameter SAMPLE_W      = 16,
  parameter CYCLES_PER_MS = `CPG_CYCLES_PER_MS
) (
  // clock and reset
  input  wire                ref_clk,
  input  wire                rst,
  // control port
  input  wire [7:0]          reg_addr,
  input  wire [7:0]          reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [7:0]          reg_rdata,
  output reg                 reg_rvalid,
  // ring delay top bit, held in another register outside this block
  input  wire                ring_delay_bit2,
  // ring validation
  input  wire                ring_validated,
  output wire                ring_indicate,
  output wire [5:0]          ring_interval_limit,
  // monitor sample paths
  input  wire [SAMPLE_W-1:0] rx_sample,
  input  wire [SAMPLE_W-1:0] tx_sample,
  input  wire                sample_valid,
  output reg  [SAMPLE_W-1:0] call_progress_monitor_out,
  output reg                 monitor_valid
);

  localparam PROD_W  = SAMPLE_W + 9;
  localparam SCALE_W = PROD_W - `CPG_GAIN_SHIFT;
  localparam SUM_W   = SCALE_W + 1;
  localparam TICK_W  = 20;

  // registers
  reg  [7:0]          monitor_receive_gain_reg;
  reg  [7:0]          monitor_tx_gain_reg;
  reg  [7:0]          ring_validation_control_one_reg;
  reg  [7:0]          rdata_next;

  // millisecond tick
  reg  [TICK_W-1:0]   tick_cnt_reg;
  reg                 ms_tick_reg;

  // monitor datapath
  wire signed [SCALE_W-1:0] rx_scaled;
  wire signed [SCALE_W-1:0] tx_scaled;
  wire signed [SUM_W-1:0]   mix_sum;
  wire [2:0]                delay_code;

  // linear gain: sample times field, divided by the unity value 64
  function signed [SCALE_W-1:0] cpg_scale;
    input signed [SAMPLE_W-1:0] s;
    input [7:0]                 g;
    reg signed [PROD_W-1:0]     p;
    begin
      p = s * $signed({1'b0, g});
      if (g == 8'h00)
        cpg_scale = {SCALE_W{1'b0}};
      else
        cpg_scale = p[PROD_W-1:`CPG_GAIN_SHIFT];
    end
  endfunction

  // clamp to the output width instead of wrapping on boosted peaks
  function [SAMPLE_W-1:0] cpg_sat;
    input signed [SUM_W-1:0] v;
    reg signed [SUM_W-1:0]   hi;
    reg signed [SUM_W-1:0]   lo;
    begin
      hi = $signed({{(SUM_W-SAMPLE_W+1){1'b0}}, {(SAMPLE_W-1){1'b1}}});
      lo = $signed({{(SUM_W-SAMPLE_W+1){1'b1}}, {(SAMPLE_W-1){1'b0}}});
      if (v > hi)
        cpg_sat = hi[SAMPLE_W-1:0];
      else if (v < lo)
        cpg_sat = lo[SAMPLE_W-1:0];
      else
        cpg_sat = v[SAMPLE_W-1:0];
    end
  endfunction

  // register writes
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      monitor_receive_gain_reg        <= `CPG_RST_RX_GAIN;
      monitor_tx_gain_reg             <= `CPG_RST_TX_GAIN;
      ring_validation_control_one_reg <= `CPG_RST_RING_CTRL1;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `CPG_OFF_RX_GAIN:
        begin
          monitor_receive_gain_reg <= reg_wdata;
        end
        `CPG_OFF_TX_GAIN:
        begin
          monitor_tx_gain_reg <= reg_wdata;
        end
        `CPG_OFF_RING_CTRL1:
        begin
          ring_validation_control_one_reg <= reg_wdata;
        end
        default:
        begin
          // other offsets belong to other blocks
        end
      endcase
    end
  end

  // register reads
  always @*
  begin
    case (reg_addr)
      `CPG_OFF_RX_GAIN:
      begin
        rdata_next = monitor_receive_gain_reg;
      end
      `CPG_OFF_TX_GAIN:
      begin
        rdata_next = monitor_tx_gain_reg;
      end
      `CPG_OFF_RING_CTRL1:
      begin
        rdata_next = ring_validation_control_one_reg;
      end
      default:
      begin
        rdata_next = 8'h00;
      end
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rdata_next;
    end
  end

  assign ring_interval_limit =
    ring_validation_control_one_reg[`CPG_LIMIT_MSB:`CPG_LIMIT_LSB];

  // millisecond tick from the system clock
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      tick_cnt_reg <= {TICK_W{1'b0}};
      ms_tick_reg  <= 1'b0;
    end
    else if (tick_cnt_reg == CYCLES_PER_MS[TICK_W-1:0] - 1'b1)
    begin
      tick_cnt_reg <= {TICK_W{1'b0}};
      ms_tick_reg  <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      ms_tick_reg  <= 1'b0;
    end
  end

  assign delay_code = {ring_delay_bit2,
    ring_validation_control_one_reg[`CPG_DELAY_LO_MSB:`CPG_DELAY_LO_LSB]};

  cpg_ring_delay #(
    .CNT_W          (`CPG_DELAY_WIDTH)
  ) u_ring_delay (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .ms_tick        (ms_tick_reg),
    .delay_code     (delay_code),
    .ring_validated (ring_validated),
    .ring_indicate  (ring_indicate)
  );

  // receive path: 64 is unity, 0 mutes, 255 about +12 dB
  assign rx_scaled = cpg_scale($signed(rx_sample),
                               monitor_receive_gain_reg);

  // transmit path uses the same law with its own field
  assign tx_scaled = cpg_scale($signed(tx_sample),
                               monitor_tx_gain_reg);

  assign mix_sum = {rx_scaled[SCALE_W-1], rx_scaled} +
                   {tx_scaled[SCALE_W-1], tx_scaled};

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      call_progress_monitor_out <= {SAMPLE_W{1'b0}};
      monitor_valid             <= 1'b0;
    end
    else
    begin
      monitor_valid <= sample_valid;
      if (sample_valid)
        call_progress_monitor_out <= cpg_sat(mix_sum);
    end
  end

endmodule // cpg_regs

// >>> tb/cpg_regs_sva.sv
module cpg_regs_chk #(
  parameter SAMPLE_W      = 16,
  parameter CYCLES_PER_MS = 50000
) (
  // clock and reset
  input wire                ref_clk,
  input wire                rst,
  // control port
  input wire [7:0]          reg_addr,
  input wire [7:0]          reg_wdata,
  input wire                reg_wr,
  input wire                reg_rd,
  input wire [7:0]          reg_rdata,
  input wire                reg_rvalid,
  // ring
  input wire                ring_delay_bit2,
  input wire                ring_validated,
  input wire                ring_indicate,
  input wire [5:0]          ring_interval_limit,
  // monitor
  input wire [SAMPLE_W-1:0] rx_sample,
  input wire [SAMPLE_W-1:0] tx_sample,
  input wire                sample_valid,
  input wire [SAMPLE_W-1:0] call_progress_monitor_out,
  input wire                monitor_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // mirror of the register file, kept from the write strobes
  reg  [7:0] rx_g_reg;
  reg  [7:0] tx_g_reg;
  reg  [7:0] ctl_reg;
  wire [7:0] rd_exp = reg_addr == 8'h14 ? rx_g_reg : reg_addr == 8'h15 ? tx_g_reg :
                      reg_addr == 8'h16 ? ctl_reg : 8'h00;
  wire [2:0] code   = {ring_delay_bit2, ctl_reg[7:6]};
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      rx_g_reg <= 8'h00;
      tx_g_reg <= 8'h00;
      ctl_reg  <= 8'h96;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h14) rx_g_reg <= reg_wdata;
      if (reg_addr == 8'h15) tx_g_reg <= reg_wdata;
      if (reg_addr == 8'h16) ctl_reg <= reg_wdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_read;
    reg_rd ##1 reg_rvalid;
  endsequence
  sequence s_mix_in(logic [7:0] gr, logic [7:0] gt);
    sample_valid && rx_g_reg == gr && tx_g_reg == gt;
  endsequence
  a_read_answer: assert property (reg_rd |-> s_read) else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
  a_read_data: assert property (reg_rd |=> reg_rdata == $past(rd_exp))
    else $error("read data wrong");
  a_mon_answer: assert property (sample_valid |=> monitor_valid) else $error("no monitor_valid");
  a_mon_hold: assert property (!sample_valid |=> $stable(call_progress_monitor_out))
    else $error("monitor out moved");
  a_mute_both: assert property (s_mix_in(8'h00, 8'h00) |=>
    call_progress_monitor_out == 0) else $error("mute not silent");
  a_rx_unity: assert property (s_mix_in(8'h40, 8'h00) |=>
    call_progress_monitor_out == $past(rx_sample)) else $error("rx unity wrong");
  a_tx_unity: assert property (s_mix_in(8'h00, 8'h40) |=>
    call_progress_monitor_out == $past(tx_sample)) else $error("tx unity wrong");
  a_ring_now: assert property (ring_validated && code == 0 |=> ring_indicate)
    else $error("no immediate ring");
  a_ring_wait: assert property (ring_validated && code != 0 |=> !ring_indicate [*8])
    else $error("ring too early");
  a_limit_field: assert property (ring_interval_limit == ctl_reg[5:0])
    else $error("limit field wrong");
endmodule // cpg_regs_chk

bind cpg_regs cpg_regs_chk #(.SAMPLE_W(SAMPLE_W), .CYCLES_PER_MS(CYCLES_PER_MS)) chk_u (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .ring_delay_bit2(ring_delay_bit2), .ring_validated(ring_validated),
  .ring_indicate(ring_indicate), .ring_interval_limit(ring_interval_limit),
  .rx_sample(rx_sample), .tx_sample(tx_sample), .sample_valid(sample_valid),
  .call_progress_monitor_out(call_progress_monitor_out), .monitor_valid(monitor_valid));

// >>> tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic        ring_delay_bit2 = 0, ring_validated = 0, sample_valid = 0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [15:0] rx_sample = 16'h0000, tx_sample = 16'h0000;
  wire  [7:0]  reg_rdata;
  wire         reg_rvalid, ring_indicate, monitor_valid;
  wire  [5:0]  ring_interval_limit;
  wire  [15:0] call_progress_monitor_out;
  int          err_count = 0, checked = 0;
  always #10 ref_clk = ~ref_clk;
  // short millisecond so the longest ring delay stays a few thousand cycles
  cpg_regs #(.SAMPLE_W(16), .CYCLES_PER_MS(4)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .ring_delay_bit2(ring_delay_bit2), .ring_validated(ring_validated),
    .ring_indicate(ring_indicate), .ring_interval_limit(ring_interval_limit),
    .rx_sample(rx_sample), .tx_sample(tx_sample), .sample_valid(sample_valid),
    .call_progress_monitor_out(call_progress_monitor_out), .monitor_valid(monitor_valid));
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick;
    reg_wr = 0;
    tick;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1;
    tick;
    reg_rd = 0;
    cmp({7'h00, reg_rvalid, reg_rdata}, {8'h01, e});
    tick;
  endtask
  function int sc(logic [15:0] s, logic [7:0] g);
    return (int'($signed(s)) * int'(g)) >>> 6;
  endfunction
  task smp(input logic [15:0] r, input logic [15:0] t, input logic [7:0] gr, input logic [7:0] gt);
    int e;
    wr(8'h14, gr);
    wr(8'h15, gt);
    e = sc(r, gr) + sc(t, gt);
    e = e > 32767 ? 32767 : e < -32768 ? -32768 : e;
    rx_sample = r;
    tx_sample = t;
    sample_valid = 1;
    tick;
    sample_valid = 0;
    cmp({15'h0000, monitor_valid}, 16'h0001);
    cmp(call_progress_monitor_out, e[15:0]);
    tick;
  endtask
  task t_reset;
    rdc(8'h14, 8'h00);
    rdc(8'h15, 8'h00);
    rdc(8'h16, 8'h96);
    cmp({10'h000, ring_interval_limit}, 16'h0016);
    wr(8'h20, 8'h5A);
    rdc(8'h20, 8'h00);
    rdc(8'h14, 8'h00);
    $display("test reset done");
  endtask
  task t_gain;
    localparam logic [39:0] RL = 40'h00_40_20_10_FF;
    localparam logic [39:0] TL = 40'h40_00_10_20_FF;
    smp(16'h1000, 16'hFF00, 8'h00, 8'h00);
    for (int i = 0; i < 5; i++)
      smp(16'h1000, 16'hFF00, RL[8*(4-i) +: 8], TL[8*(4-i) +: 8]);
    smp(16'h7000, 16'h7000, 8'hFF, 8'hFF);
    smp(16'h8000, 16'h8000, 8'hFF, 8'hFF);
    $display("test gain done");
  endtask
  task ring(input logic [2:0] c, input int pre);
    int n, lo, hi;
    wr(8'h16, {c[1:0], 6'h2A});
    cmp({10'h000, ring_interval_limit}, 16'h002A);
    ring_delay_bit2 = c[2];
    lo = c == 0 ? 0 : (c * 256 - 1) * 4;
    hi = c * 1024 + 3;
    n = 0;
    // an earlier validation whose wait the second one must throw away
    if (pre > 0)
    begin
      ring_validated = 1;
      tick;
      ring_validated = 0;
      repeat (pre) tick;
    end
    ring_validated = 1;
    tick;
    ring_validated = 0;
    while (ring_indicate !== 1'b1 && n < 8000)
    begin
      tick;
      n++;
    end
    cmp({15'h0000, n >= lo && n <= hi}, 16'h0001);
    tick;
    cmp({15'h0000, ring_indicate}, 16'h0000);
  endtask
  task t_ring;
    ring(3'd0, 0);
    ring(3'd1, 0);
    ring(3'd2, 0);
    ring(3'd7, 0);
    ring(3'd4, 0);
    ring(3'd1, 500);
    $display("test ring done");
  endtask
  task conclude;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1 rst = 0;
    t_reset;
    t_gain;
    t_ring;
    conclude;
  end
  // tests need about 16000 cycles; allow a little over three times that
  initial
  begin
    #1000000;
    err_count++;
    conclude;
  end
endmodule // tb
